// ---- logic/out_port_pkg.sv ----
// constants for the four-bit special-function output port
package out_port_pkg;

    // ------------------------------------------------------------
    // register offsets and widths
    // ------------------------------------------------------------
    localparam int         ADDR_W            = 8;
    localparam int         DATA_W            = 4;
    localparam logic [7:0] OFS_PORT_DATA     = 8'hD4;
    localparam logic [7:0] OFS_BUZZER_CTRL   = 8'hE0;
    localparam logic [7:0] OFS_CLOCK_CTRL    = 8'hE1;
    localparam logic [7:0] OFS_TIMER_CTRL    = 8'hE9;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_BUZZER_FREQ   = 0;
    localparam int BIT_PIN2_BUZZER   = 2;
    localparam int BIT_PIN3_BUZZER   = 3;
    localparam int BIT_CLK_FREQ_LO   = 0;
    localparam int BIT_CLK_FREQ_HI   = 1;
    localparam int BIT_PIN0_CLOCK    = 3;
    localparam int BIT_TIMER_RELOAD  = 0;
    localparam int BIT_TIMER_RUN     = 1;
    localparam int BIT_PIN1_TIMER    = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_PORT_DATA     = 4'h3;
    localparam logic       RST_SELECT        = 1'b0;
    localparam logic       RST_BUZZER_FREQ   = 1'b0;
    localparam logic [1:0] RST_CLK_FREQ      = 2'h0;
    localparam logic       RST_TIMER_RUN     = 1'b0;

    // ------------------------------------------------------------
    // clock frequency field codes
    // ------------------------------------------------------------
    localparam logic [1:0] CLK_SEL_512       = 2'h0;
    localparam logic [1:0] CLK_SEL_4096      = 2'h1;
    localparam logic [1:0] CLK_SEL_LOW_OSC   = 2'h2;
    localparam logic [1:0] CLK_SEL_HIGH_OSC  = 2'h3;

    // ------------------------------------------------------------
    // divider taps on the low-speed oscillator (32768 Hz nominal)
    // tap n toggles at osc / 2^(n+1)
    // ------------------------------------------------------------
    localparam int DIV_W             = 6;
    localparam int TAP_4096_HZ       = 2;
    localparam int TAP_2048_HZ       = 3;
    localparam int TAP_512_HZ        = 5;
    localparam int TAP_BUZZER_4K     = 2;
    localparam int TAP_BUZZER_2K     = 3;

endpackage

// ---- logic/glitchless_gate.sv ----
// switches a waveform on or off only while it sits low
`timescale 1ns/1ps

module glitchless_gate
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // waveform and request
    input  wire logic wave,
    input  wire logic want_on,
    // gated result
    output logic      gated
);

    logic on_q;
    logic on_d;

    // enable may only change while the wave is low, so no runt pulse
    always_comb
    begin
        on_d = on_q;
        if (!wave)
        begin
            on_d = want_on;
        end
    end

    // enable flip-flop
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            on_q <= 1'b0;
        end
        else
        begin
            on_q <= on_d;
        end
    end

    // wave passes only while enabled
    assign gated = on_q & wave;

endmodule

// ---- logic/output_port_special_mux.sv ----
// four-bit output port with clock, timer pulse and buzzer special outputs
`timescale 1ns/1ps

module output_port_special_mux
(
    // clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    // register port
    input  wire logic [out_port_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [out_port_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [out_port_pkg::DATA_W-1:0]    reg_rdata,
    // oscillator clocks from outside this clock domain
    input  wire logic                               low_speed_osc_freq,
    input  wire logic                               high_speed_osc_freq,
    // programmable timer
    input  wire logic                               timer_overflow,
    output logic                                    timer_run_stop,
    output logic                                    timer_reload_strobe,
    // output pins
    output logic                                    out_pin0_data,
    output logic                                    out_pin1_data,
    output logic                                    out_pin2_data,
    output logic                                    out_pin3_data
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [3:0] port_data_q;
    logic       pin2_buzzer_select_q;
    logic       pin3_inverted_buzzer_select_q;
    logic       buzzer_freq_select_q;
    logic       pin0_clock_select_q;
    logic       clock_freq_sel_lo_q;
    logic       clock_freq_sel_hi_q;
    logic       pin1_timer_select_q;
    logic       timer_run_q;
    logic       reload_q;
    logic [3:0] rdata_q;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic wr_data;
    logic wr_buzzer;
    logic wr_clock;
    logic wr_timer;

    assign wr_data   = reg_wr && (reg_addr == out_port_pkg::OFS_PORT_DATA);
    assign wr_buzzer = reg_wr && (reg_addr == out_port_pkg::OFS_BUZZER_CTRL);
    assign wr_clock  = reg_wr && (reg_addr == out_port_pkg::OFS_CLOCK_CTRL);
    assign wr_timer  = reg_wr && (reg_addr == out_port_pkg::OFS_TIMER_CTRL);

    // port data register, stored unchanged
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            port_data_q <= out_port_pkg::RST_PORT_DATA;
        end
        else if (wr_data)
        begin
            port_data_q <= reg_wdata;
        end
    end

    // buzzer selection and frequency bits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin2_buzzer_select_q          <= out_port_pkg::RST_SELECT;
            pin3_inverted_buzzer_select_q <= out_port_pkg::RST_SELECT;
            buzzer_freq_select_q          <= out_port_pkg::RST_BUZZER_FREQ;
        end
        else if (wr_buzzer)
        begin
            pin2_buzzer_select_q          <= reg_wdata[out_port_pkg::BIT_PIN2_BUZZER];
            pin3_inverted_buzzer_select_q <= reg_wdata[out_port_pkg::BIT_PIN3_BUZZER];
            buzzer_freq_select_q          <= reg_wdata[out_port_pkg::BIT_BUZZER_FREQ];
        end
    end

    // clock output selection and frequency field
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin0_clock_select_q <= out_port_pkg::RST_SELECT;
            clock_freq_sel_lo_q <= out_port_pkg::RST_CLK_FREQ[0];
            clock_freq_sel_hi_q <= out_port_pkg::RST_CLK_FREQ[1];
        end
        else if (wr_clock)
        begin
            pin0_clock_select_q <= reg_wdata[out_port_pkg::BIT_PIN0_CLOCK];
            clock_freq_sel_lo_q <= reg_wdata[out_port_pkg::BIT_CLK_FREQ_LO];
            clock_freq_sel_hi_q <= reg_wdata[out_port_pkg::BIT_CLK_FREQ_HI];
        end
    end

    // timer selection and run bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin1_timer_select_q <= out_port_pkg::RST_SELECT;
            timer_run_q         <= out_port_pkg::RST_TIMER_RUN;
        end
        else if (wr_timer)
        begin
            pin1_timer_select_q <= reg_wdata[out_port_pkg::BIT_PIN1_TIMER];
            timer_run_q         <= reg_wdata[out_port_pkg::BIT_TIMER_RUN];
        end
    end

    // reload is a one-cycle strobe, never stored for readback
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reload_q <= 1'b0;
        end
        else
        begin
            reload_q <= wr_timer && reg_wdata[out_port_pkg::BIT_TIMER_RELOAD];
        end
    end

    assign timer_run_stop      = timer_run_q;
    assign timer_reload_strobe = reload_q;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [3:0] rd_value;

    // read mux; unused and write-only bits read zero
    always_comb
    begin
        rd_value = 4'h0;
        case (reg_addr)
            out_port_pkg::OFS_PORT_DATA:
            begin
                rd_value = port_data_q;
            end
            out_port_pkg::OFS_BUZZER_CTRL:
            begin
                rd_value[out_port_pkg::BIT_PIN3_BUZZER] = pin3_inverted_buzzer_select_q;
                rd_value[out_port_pkg::BIT_PIN2_BUZZER] = pin2_buzzer_select_q;
                rd_value[out_port_pkg::BIT_BUZZER_FREQ] = buzzer_freq_select_q;
            end
            out_port_pkg::OFS_CLOCK_CTRL:
            begin
                rd_value[out_port_pkg::BIT_PIN0_CLOCK]  = pin0_clock_select_q;
                rd_value[out_port_pkg::BIT_CLK_FREQ_HI] = clock_freq_sel_hi_q;
                rd_value[out_port_pkg::BIT_CLK_FREQ_LO] = clock_freq_sel_lo_q;
            end
            out_port_pkg::OFS_TIMER_CTRL:
            begin
                rd_value[out_port_pkg::BIT_PIN1_TIMER] = pin1_timer_select_q;
                rd_value[out_port_pkg::BIT_TIMER_RUN]  = timer_run_q;
            end
            default:
            begin
                rd_value = 4'h0;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 4'h0;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_value : 4'h0;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // oscillator synchronisers
    // ------------------------------------------------------------
    logic [1:0] low_sync_q;
    logic [1:0] high_sync_q;
    logic       low_prev_q;

    // two flops each; only the second stage is read by logic
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            low_sync_q  <= 2'h0;
            high_sync_q <= 2'h0;
            low_prev_q  <= 1'b0;
        end
        else
        begin
            low_sync_q  <= {low_sync_q[0], low_speed_osc_freq};
            high_sync_q <= {high_sync_q[0], high_speed_osc_freq};
            low_prev_q  <= low_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // divider on the low-speed oscillator
    // ------------------------------------------------------------
    logic [out_port_pkg::DIV_W-1:0] div_q;
    logic                           low_rise;

    assign low_rise = low_sync_q[1] && !low_prev_q;

    // counts rising edges of the synchronised oscillator
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
        end
        else if (low_rise)
        begin
            div_q <= div_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    logic [1:0] clock_freq_code;
    logic       divided_clock_out_src;
    logic       buzzer_signal;

    assign clock_freq_code = {clock_freq_sel_hi_q, clock_freq_sel_lo_q};

    // pin 0 clock source
    always_comb
    begin
        case (clock_freq_code)
            out_port_pkg::CLK_SEL_HIGH_OSC: divided_clock_out_src = high_sync_q[1];
            out_port_pkg::CLK_SEL_LOW_OSC:  divided_clock_out_src = low_sync_q[1];
            out_port_pkg::CLK_SEL_4096:     divided_clock_out_src = div_q[out_port_pkg::TAP_4096_HZ];
            out_port_pkg::CLK_SEL_512:      divided_clock_out_src = div_q[out_port_pkg::TAP_512_HZ];
            default:                        divided_clock_out_src = 1'b0;
        endcase
    end

    // buzzer waveform: 1 selects 2 kHz, 0 selects 4 kHz
    assign buzzer_signal = buzzer_freq_select_q ? div_q[out_port_pkg::TAP_BUZZER_2K]
                                                : div_q[out_port_pkg::TAP_BUZZER_4K];

    // ------------------------------------------------------------
    // glitch-free gating of each special signal
    // ------------------------------------------------------------
    logic divided_clock_out_gated;
    logic ovf_gated;
    logic bz_gated;
    logic bz_inv_gated;

    // clock on pin 0 runs while data bit is 0
    glitchless_gate u_gate_divided_clock_out
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .wave    (divided_clock_out_src),
        .want_on (!port_data_q[0]),
        .gated   (divided_clock_out_gated)
    );

    // timer pulse on pin 1 passes while data bit is 0
    glitchless_gate u_gate_ovf
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .wave    (timer_overflow),
        .want_on (!port_data_q[1]),
        .gated   (ovf_gated)
    );

    // buzzer on pin 2 runs while data bit is 1
    glitchless_gate u_gate_bz
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .wave    (buzzer_signal),
        .want_on (port_data_q[2]),
        .gated   (bz_gated)
    );

    // inverted buzzer on pin 3 runs while data bit is 1
    glitchless_gate u_gate_bz_inv
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .wave    (!buzzer_signal),
        .want_on (port_data_q[3]),
        .gated   (bz_inv_gated)
    );

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic pin0_q;
    logic pin1_q;
    logic pin2_q;
    logic pin3_q;

    // special outputs on pins 0 and 1 idle high, active low
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin0_q <= out_port_pkg::RST_PORT_DATA[0];
            pin1_q <= out_port_pkg::RST_PORT_DATA[1];
        end
        else
        begin
            pin0_q <= pin0_clock_select_q ? !divided_clock_out_gated : port_data_q[0];
            pin1_q <= pin1_timer_select_q ? !ovf_gated  : port_data_q[1];
        end
    end

    // buzzer pins idle low; DC mode follows the data bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin2_q <= out_port_pkg::RST_PORT_DATA[2];
            pin3_q <= out_port_pkg::RST_PORT_DATA[3];
        end
        else
        begin
            pin2_q <= pin2_buzzer_select_q          ? bz_gated     : port_data_q[2];
            pin3_q <= pin3_inverted_buzzer_select_q ? bz_inv_gated : port_data_q[3];
        end
    end

    // the timer itself must be started by software for pin 1 to pulse
    assign out_pin0_data = pin0_q;
    assign out_pin1_data = pin1_q;
    assign out_pin2_data = pin2_q;
    assign out_pin3_data = pin3_q;

endmodule

// ---- tb/port_chk_sva.sv ----
// assertion checker for the special-function output port
`timescale 1ns/1ps

module port_chk
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [3:0] reg_rdata,
    // timer and pins
    input wire logic       timer_run_stop,
    input wire logic       timer_reload_strobe,
    input wire logic       out_pin0_data,
    input wire logic       out_pin1_data,
    input wire logic       out_pin2_data,
    input wire logic       out_pin3_data
);
    localparam int SETTLE = 600;
    logic [3:0] data_q;
    logic [3:0] sel_q;
    logic       run_q;
    int         quiet_q;
    int         dc_q;
    wire        hit_d4 = reg_addr == out_port_pkg::OFS_PORT_DATA;
    wire        hit_e9 = reg_addr == out_port_pkg::OFS_TIMER_CTRL;
    wire        reload = reg_wr && hit_e9 && reg_wdata[0];
    wire        rd_d4  = reg_rd && hit_d4;
    wire [3:0]  pins   = {out_pin3_data, out_pin2_data, out_pin1_data, out_pin0_data};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the port data, select and run bits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_q <= out_port_pkg::RST_PORT_DATA;
            sel_q  <= 4'h0;
            run_q  <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (hit_d4)
                data_q <= reg_wdata;
            if (reg_addr == out_port_pkg::OFS_BUZZER_CTRL)
                sel_q[3:2] <= reg_wdata[3:2];
            if (reg_addr == out_port_pkg::OFS_CLOCK_CTRL)
                sel_q[0] <= reg_wdata[3];
            if (hit_e9)
                sel_q[1] <= reg_wdata[3];
            if (hit_e9)
                run_q <= reg_wdata[1];
        end
    end

    // cycles since the last write
    always_ff @(posedge clk)
    begin
        if (!rst_n || reg_wr)
            quiet_q <= 0;
        else if (quiet_q < SETTLE)
            quiet_q <= quiet_q + 1;
    end

    // cycles since any special output was selected
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dc_q <= SETTLE;
        else if (sel_q != 4'h0)
            dc_q <= 0;
        else if (dc_q < SETTLE)
            dc_q <= dc_q + 1;
    end

    sequence s_strobe;
        timer_reload_strobe ##1 !timer_reload_strobe;
    endsequence

    chk_dc_follow:
        assert property (dc_q >= SETTLE && quiet_q >= 2 |-> pins == data_q)
        else $error("dc pins differ from port data");
    chk_clk_high:
        assert property (sel_q[0] && data_q[0] && quiet_q >= SETTLE |-> out_pin0_data)
        else $error("clock pin not held high");
    chk_pulse_high:
        assert property (sel_q[1] && data_q[1] && quiet_q >= SETTLE |-> out_pin1_data)
        else $error("timer pin not held high");
    chk_buzz_low:
        assert property (sel_q[2] && !data_q[2] && quiet_q >= SETTLE |-> !out_pin2_data)
        else $error("buzzer pin not low when off");
    chk_buzz_inverse:
        assert property (&sel_q[3:2] && &data_q[3:2] && quiet_q >= SETTLE
                         |-> out_pin3_data != out_pin2_data)
        else $error("buzzer pair not inverse");
    chk_run_level:
        assert property (timer_run_stop == run_q)
        else $error("run output differs from written bit");
    chk_reload_pulse:
        assert property (reload |=> s_strobe)
        else $error("reload strobe missing or too long");
    chk_reload_cause:
        assert property (timer_reload_strobe |-> $past(reload))
        else $error("reload strobe without request");
    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 4'h0)
        else $error("read data not zero when idle");
    chk_read_data:
        assert property ($past(rd_d4) |-> reg_rdata == $past(data_q))
        else $error("port data read back wrong");
endmodule

bind output_port_special_mux port_chk port_chk_inst
(
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_run_stop(timer_run_stop), .timer_reload_strobe(timer_reload_strobe),
    .out_pin0_data(out_pin0_data), .out_pin1_data(out_pin1_data),
    .out_pin2_data(out_pin2_data), .out_pin3_data(out_pin3_data)
);

// ---- tb/source_model.sv ----
// oscillator and programmable timer sources feeding the port
`timescale 1ns/1ps

module source_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // timer control from the port
    input  wire logic timer_run_stop,
    input  wire logic timer_reload_strobe,
    // sources toward the port
    output logic      low_speed_osc_freq,
    output logic      high_speed_osc_freq,
    output logic      timer_overflow
);
    logic [1:0] lo_q;
    logic [1:0] hi_q;
    logic [4:0] tmr_q;

    // oscillators, four and three cycles a level
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            lo_q                <= 2'h0;
            hi_q                <= 2'h0;
            low_speed_osc_freq  <= 1'b0;
            high_speed_osc_freq <= 1'b0;
        end
        else
        begin
            lo_q <= lo_q + 2'h1;
            hi_q <= (hi_q == 2'h2) ? 2'h0 : hi_q + 2'h1;
            if (lo_q == 2'h3)
                low_speed_osc_freq <= ~low_speed_osc_freq;
            if (hi_q == 2'h2)
                high_speed_osc_freq <= ~high_speed_osc_freq;
        end
    end

    // overflow every twenty cycles, only while running
    always_ff @(posedge clk)
    begin
        if (!rst_n || timer_reload_strobe || !timer_run_stop)
            tmr_q <= 5'h00;
        else
            tmr_q <= (tmr_q == 5'h13) ? 5'h00 : tmr_q + 5'h01;
        timer_overflow <= rst_n && timer_run_stop && tmr_q == 5'h13;
    end
endmodule

// ---- tb/tb_top.sv ----
// testbench for the special-function output port
`timescale 1ns/1ps

module tb_top;
    localparam logic [7:0] A_D4 = out_port_pkg::OFS_PORT_DATA;
    localparam logic [7:0] A_E0 = out_port_pkg::OFS_BUZZER_CTRL;
    localparam logic [7:0] A_E1 = out_port_pkg::OFS_CLOCK_CTRL;
    localparam logic [7:0] A_E9 = out_port_pkg::OFS_TIMER_CTRL;
    // clock periods: 512 Hz, 4096 Hz, slow and fast oscillator
    int         cper[4] = '{512, 64, 8, 6};
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [3:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [3:0] reg_rdata;
    logic       lo_osc;
    logic       hi_osc;
    logic       tovf;
    logic       run;
    logic       rld;
    wire  [3:0] pins;
    logic       hit;
    logic       prev;
    int         error_cnt;
    int         checks_done;

    output_port_special_mux output_port_special_mux_inst
    (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .low_speed_osc_freq(lo_osc), .high_speed_osc_freq(hi_osc),
        .timer_overflow(tovf), .timer_run_stop(run), .timer_reload_strobe(rld),
        .out_pin0_data(pins[0]), .out_pin1_data(pins[1]),
        .out_pin2_data(pins[2]), .out_pin3_data(pins[3])
    );

    source_model source_model_inst
    (
        .clk(clk), .rst_n(rst_n), .timer_run_stop(run), .timer_reload_strobe(rld),
        .low_speed_osc_freq(lo_osc), .high_speed_osc_freq(hi_osc),
        .timer_overflow(tovf)
    );

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask

    // period between the second and third rising edge of a pin
    task automatic meas(input int idx, input int exp);
        int   n;
        int   r;
        int   t0;
        logic p;
        n = 0;
        r = 0;
        t0 = 0;
        p = 1'b1;
        while (r < 3 && n < 4000)
        begin
            @(posedge clk);
            #1;
            n++;
            if (pins[idx] === 1'b1 && p === 1'b0)
            begin
                r++;
                t0 = (r == 3) ? n - t0 : n;
            end
            p = pins[idx];
        end
        checks_done++;
        if (r < 3 || t0 != exp)
        begin
            error_cnt++;
            $display("MISMATCH period pin %0d expected %0d seen %0d", idx, exp, t0);
        end
        if (r < 3)
            complete_run();
    endtask

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset pins", 4'h3, pins);
        rd(A_D4, 4'h3);
        rd(A_E0, 4'h0);
        rd(A_E1, 4'h0);
        rd(A_E9, 4'h0);
        $display("test reset done");
        for (int v = 0; v < 16; v++)
        begin
            wr(A_D4, 4'(v));
            repeat (2) @(posedge clk);
            #1;
            chk("dc pins", 4'(v), pins);
            rd(A_D4, 4'(v));
        end
        $display("test dc done");
        wr(A_E0, 4'hF);
        rd(A_E0, 4'hD);
        wr(A_E1, 4'hF);
        rd(A_E1, 4'hB);
        wr(A_E1, 4'h0);
        wr(A_E9, 4'hF);
        #1;
        chk("reload strobe", 4'h1, {3'h0, rld});
        rd(A_E9, 4'hA);
        chk("run", 4'h1, {3'h0, run});
        wr(8'hE2, 4'hF);
        rd(8'hE2, 4'h0);
        wr(A_E9, 4'h0);
        $display("test registers done");
        wr(A_E0, 4'hC);
        wr(A_D4, 4'hC);
        meas(2, 64);
        wr(A_E0, 4'hD);
        meas(2, 128);
        meas(3, 128);
        repeat (700) @(posedge clk);
        wr(A_D4, 4'h0);
        repeat (700) @(posedge clk);
        #1;
        chk("buzzer off", 4'h0, pins);
        $display("test buzzer done");
        wr(A_E0, 4'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(A_E1, 4'(8 + c));
            meas(0, cper[c]);
        end
        wr(A_D4, 4'h1);
        repeat (700) @(posedge clk);
        #1;
        chk("clock hold", 4'h1, pins);
        $display("test clock done");
        wr(A_E1, 4'h0);
        wr(A_D4, 4'h0);
        wr(A_E9, 4'hA);
        hit = 1'b0;
        prev = 1'b0;
        for (int n = 0; n < 300; n++)
        begin
            @(posedge clk);
            #1;
            if (prev === 1'b1 && pins[1] === 1'b0)
                hit = 1'b1;
            prev = pins[1];
        end
        chk("timer pulse", 4'h1, {3'h0, hit});
        wr(A_D4, 4'h2);
        repeat (700) @(posedge clk);
        #1;
        chk("timer hold", 4'h2, pins);
        wr(A_E9, 4'h0);
        $display("test timer done");
        complete_run();
    end
endmodule
